//--- hw/emfm_pkg.sv
// constants, register map and types of the engine motor fault monitor
package emfm_pkg;
   // timing base: one tick per millisecond
   localparam int CLK_MHZ      = 25;
   localparam int TICK_US      = 1000;
   localparam int TICK_CYCLES  = CLK_MHZ * TICK_US;
   localparam logic [15:0] FAN_BOOST_MS   = 16'd2000;
   localparam logic [15:0] LOCK_HOLD_MS   = 16'd500;
   localparam logic [15:0] MOTOR_WIN_MS   = 16'd1000;
   localparam logic [15:0] PRESS_LIMIT_MS = 16'd4000;
   localparam logic [15:0] SCAN_WIN_MS    = 16'd8000;
   localparam logic [15:0] SCAN_LOST_MS   = 16'd400;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] STATUS_OFS  = 8'h04;
   localparam logic [7:0] MASK_OFS    = 8'h08;
   localparam logic [7:0] SOS_OFS     = 8'h0c;
   localparam logic [7:0] BELT_OFS    = 8'h10;
   localparam logic [7:0] CLEAN_OFS   = 8'h14;
   localparam logic [7:0] STATE_OFS   = 8'h18;
   localparam logic [7:0] CMD_OFS     = 8'h1c;
   // reset values
   localparam logic [11:0] CTRL_RST   = 12'h000;
   localparam logic [6:0]  MASK_RST   = 7'h00;
   localparam logic [15:0] SOS_RST    = 16'h000a;
   localparam logic [15:0] BELT_RST   = 16'h07d0;
   localparam logic [15:0] CLEAN_RST  = 16'h0bb8;
   // control bits
   localparam int C_FAN_EN    = 0;
   localparam int C_TRANSPORT = 1;
   localparam int C_FUSER     = 2;
   localparam int C_ENGAGE    = 3;
   localparam int C_PRESS_ACT = 4;
   localparam int C_SCANNER   = 5;
   localparam int C_EMIT      = 6;
   localparam int C_BELT      = 7;
   localparam int C_CLEANER   = 8;
   localparam int C_COLOR     = 9;
   localparam int C_PAUSE     = 10;
   localparam int CTRL_W      = 12;
   // command bits
   localparam int K_FAN_START = 0;
   localparam int K_WARM_DONE = 1;
   // fault bits
   localparam int F_FAN       = 0;
   localparam int F_TRANSPORT = 1;
   localparam int F_FUSER     = 2;
   localparam int F_PRESS     = 3;
   localparam int F_LASER     = 4;
   localparam int F_BELT      = 5;
   localparam int F_CLEANER   = 6;
   localparam int FAULT_W     = 7;
   typedef enum logic [2:0] {
      FAN_OFF   = 3'b001,
      FAN_BOOST = 3'b010,
      FAN_HALF  = 3'b100
   } emfm_fan_type;
endpackage : emfm_pkg

//--- hw/emfm_monitor.sv
// fusing fan control and motor, laser, belt and cleaner fault timing
`timescale 1ns/100ps

module emfm_hold_timer (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // timing control
   input  wire logic        tick,
   input  wire logic        run,
   input  wire logic        restart,
   input  wire logic [15:0] limit,
   // result
   output logic             done
);
   logic [15:0] count_reg;

   // counts ticks while run holds, saturates at the limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 16'h0000;
      end else if (!run || restart) begin
         count_reg <= 16'h0000;
      end else if (tick && count_reg < limit) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // a limit lowered below the count still ends the wait, no wrap through zero
   assign done = run && !restart && (count_reg >= limit);

   a_timer_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !run |=> count_reg == 16'h0000) else $error("timer not cleared");
   a_timer_step: assert property (@(posedge pclk) disable iff (!presetn)
      run && !restart && tick && count_reg < limit |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("timer did not advance");
endmodule : emfm_hold_timer

module emfm_monitor
   import emfm_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // machine indications
   input  wire logic        cover_open,
   input  wire logic        fan_lock,
   input  wire logic        transport_lock,
   input  wire logic        fuser_lock,
   input  wire logic        scanner_lock,
   input  wire logic        scan_start_pulse,
   input  wire logic        press_engaged_sensor,
   input  wire logic        press_retracted_sensor,
   input  wire logic        belt_position_sensor,
   input  wire logic        cleaner_retract_sensor,
   // fusing fan drive
   output logic             fan_full,
   output logic             fan_half,
   // interrupt
   output logic             irq
);
   logic [CTRL_W-1:0]  ctrl_reg;
   logic [FAULT_W-1:0] status_reg;
   logic [FAULT_W-1:0] status_next;
   logic [FAULT_W-1:0] fault_set;
   logic [FAULT_W-1:0] mask_reg;
   logic [15:0]        sos_lim_reg;
   logic [15:0]        belt_lim_reg;
   logic [15:0]        clean_lim_reg;
   logic [31:0]        prdata_reg;
   logic [31:0]        rd_value;
   logic               rd_hit;
   logic [14:0]        div_reg;
   logic               tick;
   logic               wr_en;
   logic               fan_start;
   logic               warm_done;
   emfm_fan_type       fan_reg;
   emfm_fan_type       fan_next;
   logic               fan_full_reg;
   logic               fan_half_reg;
   logic               fan_stop;
   logic               irq_reg;
   logic               engage_prev_reg;
   logic               belt_prev_reg;
   logic               clean_prev_reg;
   logic               boost_done;
   logic               fan_fault_done;
   logic               trans_win_done;
   logic               trans_lock_done;
   logic               fuser_win_done;
   logic               fuser_lock_done;
   logic               press_eng_done;
   logic               press_ret_done;
   logic               scan_win_done;
   logic               scan_lost_done;
   logic               sos_done;
   logic               belt_done;
   logic               clean_done;
   logic               engage_edge;
   logic               belt_edge;
   logic               clean_edge;

   // millisecond tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 15'h0000;
      end else if (div_reg == 15'(TICK_DIV - 1)) begin
         div_reg <= 15'h0000;
      end else begin
         div_reg <= div_reg + 15'h0001;
      end
   end
   assign tick = (div_reg == 15'(TICK_DIV - 1));

   // apb access, no wait states
   assign wr_en     = psel && penable && pwrite;
   assign pready    = 1'b1;
   assign prdata    = prdata_reg;
   assign fan_start = wr_en && paddr == CMD_OFS && pwdata[K_FAN_START];
   assign warm_done = wr_en && paddr == CMD_OFS && pwdata[K_WARM_DONE];

   always_comb begin
      rd_hit   = 1'b1;
      rd_value = 32'h0000_0000;
      case (paddr)
         CTRL_OFS:   rd_value = {20'h00000, ctrl_reg};
         STATUS_OFS: rd_value = {25'h0000000, status_reg};
         MASK_OFS:   rd_value = {25'h0000000, mask_reg};
         SOS_OFS:    rd_value = {16'h0000, sos_lim_reg};
         BELT_OFS:   rd_value = {16'h0000, belt_lim_reg};
         CLEAN_OFS:  rd_value = {16'h0000, clean_lim_reg};
         STATE_OFS:  rd_value = {16'h0000, scan_win_done, fuser_win_done, trans_win_done,
                                 cleaner_retract_sensor, belt_position_sensor,
                                 press_retracted_sensor, press_engaged_sensor,
                                 fan_half_reg, fan_full_reg, 4'h0, fan_reg};
         CMD_OFS:    rd_value = 32'h0000_0000;
         default:    rd_hit   = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !rd_hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= rd_value;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg      <= CTRL_RST;
         mask_reg      <= MASK_RST;
         sos_lim_reg   <= SOS_RST;
         belt_lim_reg  <= BELT_RST;
         clean_lim_reg <= CLEAN_RST;
      end else if (wr_en) begin
         case (paddr)
            CTRL_OFS:  ctrl_reg      <= pwdata[CTRL_W-1:0];
            MASK_OFS:  mask_reg      <= pwdata[FAULT_W-1:0];
            SOS_OFS:   sos_lim_reg   <= pwdata[15:0];
            BELT_OFS:  belt_lim_reg  <= pwdata[15:0];
            CLEAN_OFS: clean_lim_reg <= pwdata[15:0];
            default:   ;
         endcase
      end
   end

   // fusing fan sequencing
   emfm_hold_timer u_boost (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(fan_reg == FAN_BOOST), .restart(fan_start || warm_done),
      .limit(FAN_BOOST_MS), .done(boost_done));

   always_comb begin
      fan_next = fan_reg;
      case (fan_reg)
         FAN_OFF:   if (ctrl_reg[C_FAN_EN] && fan_start) fan_next = FAN_BOOST;
         FAN_BOOST: if (boost_done) fan_next = FAN_HALF;
         FAN_HALF:  if (fan_start || warm_done) fan_next = FAN_BOOST;
         default:   fan_next = FAN_OFF;
      endcase
      if (!ctrl_reg[C_FAN_EN]) begin
         fan_next = FAN_OFF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_reg <= FAN_OFF;
      end else begin
         fan_reg <= fan_next;
      end
   end

   assign fan_stop = cover_open || ctrl_reg[C_PAUSE];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_full_reg <= 1'b0;
         fan_half_reg <= 1'b0;
      end else if (fan_stop || fan_reg == FAN_OFF) begin
         fan_full_reg <= 1'b0;
         fan_half_reg <= 1'b0;
      end else if (ctrl_reg[C_TRANSPORT] || fan_reg == FAN_BOOST) begin
         fan_full_reg <= 1'b1;
         fan_half_reg <= 1'b0;
      end else begin
         fan_full_reg <= 1'b0;
         fan_half_reg <= 1'b1;
      end
   end
   assign fan_full = fan_full_reg;
   assign fan_half = fan_half_reg;

   a_fan_stop: assert property (@(posedge pclk) disable iff (!presetn)
      fan_stop |=> !fan_full && !fan_half) else $error("fan runs while stopped");
   a_fan_full_run: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_reg[C_TRANSPORT] && !fan_stop && fan_reg != FAN_OFF |=> fan_full)
      else $error("fan not full with transport");
   a_fan_one_speed: assert property (@(posedge pclk) disable iff (!presetn)
      !(fan_full && fan_half)) else $error("two fan speeds at once");
   a_fan_boost_end: assert property (@(posedge pclk) disable iff (!presetn)
      fan_reg == FAN_BOOST && boost_done && ctrl_reg[C_FAN_EN] |=> fan_reg == FAN_HALF)
      else $error("boost did not drop to half");

   // engage command and sensor edges for restart of change watchdogs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         engage_prev_reg <= 1'b0;
         belt_prev_reg   <= 1'b0;
         clean_prev_reg  <= 1'b0;
      end else begin
         engage_prev_reg <= ctrl_reg[C_ENGAGE];
         belt_prev_reg   <= belt_position_sensor;
         clean_prev_reg  <= cleaner_retract_sensor;
      end
   end
   assign engage_edge = engage_prev_reg != ctrl_reg[C_ENGAGE];
   assign belt_edge   = belt_prev_reg != belt_position_sensor;
   assign clean_edge  = clean_prev_reg != cleaner_retract_sensor;

   // fault timers
   emfm_hold_timer u_fan_lock (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(fan_lock), .restart(1'b0), .limit(LOCK_HOLD_MS), .done(fan_fault_done));
   emfm_hold_timer u_trans_win (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(ctrl_reg[C_TRANSPORT]), .restart(1'b0), .limit(MOTOR_WIN_MS),
      .done(trans_win_done));
   emfm_hold_timer u_trans_lock (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(trans_win_done && transport_lock), .restart(1'b0), .limit(LOCK_HOLD_MS),
      .done(trans_lock_done));
   emfm_hold_timer u_fuser_win (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(ctrl_reg[C_FUSER]), .restart(1'b0), .limit(MOTOR_WIN_MS),
      .done(fuser_win_done));
   emfm_hold_timer u_fuser_lock (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(fuser_win_done && fuser_lock), .restart(1'b0), .limit(LOCK_HOLD_MS),
      .done(fuser_lock_done));
   emfm_hold_timer u_press_eng (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(ctrl_reg[C_PRESS_ACT] && ctrl_reg[C_ENGAGE] && !press_engaged_sensor),
      .restart(engage_edge), .limit(PRESS_LIMIT_MS), .done(press_eng_done));
   emfm_hold_timer u_press_ret (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(ctrl_reg[C_PRESS_ACT] && !ctrl_reg[C_ENGAGE] && !press_retracted_sensor),
      .restart(engage_edge), .limit(PRESS_LIMIT_MS), .done(press_ret_done));
   emfm_hold_timer u_scan_win (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(ctrl_reg[C_SCANNER]), .restart(1'b0), .limit(SCAN_WIN_MS),
      .done(scan_win_done));
   emfm_hold_timer u_scan_lost (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(scan_win_done && !scanner_lock), .restart(1'b0), .limit(SCAN_LOST_MS),
      .done(scan_lost_done));
   // one watchdog covers first pulse after emission start and gaps between pulses
   emfm_hold_timer u_sos (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(ctrl_reg[C_SCANNER] && ctrl_reg[C_EMIT]), .restart(scan_start_pulse),
      .limit(sos_lim_reg), .done(sos_done));
   emfm_hold_timer u_belt (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(ctrl_reg[C_BELT]), .restart(belt_edge), .limit(belt_lim_reg),
      .done(belt_done));
   emfm_hold_timer u_clean (.pclk(pclk), .presetn(presetn), .tick(tick),
      .run(ctrl_reg[C_CLEANER] && ctrl_reg[C_COLOR] && ctrl_reg[C_PRESS_ACT]),
      .restart(clean_edge), .limit(clean_lim_reg), .done(clean_done));

   // sticky faults, hardware set wins over software clear
   always_comb begin
      fault_set              = '0;
      fault_set[F_FAN]       = fan_fault_done;
      fault_set[F_TRANSPORT] = trans_lock_done;
      fault_set[F_FUSER]     = fuser_lock_done;
      fault_set[F_PRESS]     = press_eng_done || press_ret_done;
      fault_set[F_LASER]     = scan_lost_done || sos_done;
      fault_set[F_BELT]      = belt_done;
      fault_set[F_CLEANER]   = clean_done;
      status_next = status_reg;
      if (wr_en && paddr == STATUS_OFS) begin
         status_next = status_reg & ~pwdata[FAULT_W-1:0];
      end
      status_next = status_next | fault_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= '0;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_reg    <= |(status_next & mask_reg);
      end
   end
   assign irq = irq_reg;

   a_fan_fault: assert property (@(posedge pclk) disable iff (!presetn)
      fan_fault_done |=> status_reg[F_FAN]) else $error("fan fault missed");
   a_trans_window: assert property (@(posedge pclk) disable iff (!presetn)
      !trans_win_done |=> !trans_lock_done) else $error("transport watched early");
   a_fuser_fault: assert property (@(posedge pclk) disable iff (!presetn)
      fuser_lock_done |=> status_reg[F_FUSER]) else $error("fuser fault missed");

   // transport fault: window open, lock held to the limit, flag one cycle later
   sequence s_trans_armed;
      trans_win_done && transport_lock;
   endsequence
   sequence s_trans_due;
      s_trans_armed ##0 trans_lock_done;
   endsequence
   a_trans_fault: assert property (@(posedge pclk) disable iff (!presetn)
      s_trans_due |=> status_reg[F_TRANSPORT]) else $error("transport fault missed");
   a_belt_fault: assert property (@(posedge pclk) disable iff (!presetn)
      belt_done |=> status_reg[F_BELT]) else $error("belt fault missed");

   a_press_fault: assert property (@(posedge pclk) disable iff (!presetn)
      press_eng_done || press_ret_done |=> status_reg[F_PRESS])
      else $error("pressure fault missed");
   a_fault_latch: assert property (@(posedge pclk) disable iff (!presetn)
      status_reg[F_LASER] && !(wr_en && paddr == STATUS_OFS && pwdata[F_LASER])
      |=> status_reg[F_LASER]) else $error("laser fault dropped");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq == |($past(status_next) & $past(mask_reg))) else $error("irq level wrong");
endmodule : emfm_monitor

//--- tb/emfm_partner.sv
// behavioural motors, fan lock outputs and position sensors
`timescale 1ns/100ps

module emfm_partner
   import emfm_pkg::*;
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // commanded drive and injected faults
   input  wire logic [CTRL_W-1:0] ctrl,
   input  wire logic [7:0]        fail,
   // indications
   output logic                   fan_lock,
   output logic                   transport_lock,
   output logic                   fuser_lock,
   output logic                   scanner_lock,
   output logic                   scan_start_pulse,
   output logic                   press_engaged_sensor,
   output logic                   press_retracted_sensor,
   output logic                   belt_position_sensor,
   output logic                   cleaner_retract_sensor
);
   logic [5:0] div_reg;
   logic       pos_reg;
   logic       belt_reg;
   logic       clean_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg   <= 6'h00;
         pos_reg   <= 1'b0;
         belt_reg  <= 1'b0;
         clean_reg <= 1'b0;
      end else begin
         div_reg <= div_reg + 6'h01;
         // roller travel takes up to 64 cycles, a stuck drive never arrives
         if (div_reg == 6'h00 && !fail[F_PRESS])
            pos_reg <= ctrl[C_ENGAGE];
         if (div_reg[1:0] == 2'h0 && ctrl[C_BELT] && !fail[F_BELT])
            belt_reg <= ~belt_reg;
         if (div_reg[1:0] == 2'h0 && ctrl[C_CLEANER] && !fail[F_CLEANER])
            clean_reg <= ~clean_reg;
      end
   end

   assign fan_lock               = fail[F_FAN];
   assign transport_lock         = fail[F_TRANSPORT];
   assign fuser_lock             = fail[F_FUSER];
   assign scanner_lock           = ctrl[C_SCANNER] & ~fail[7];
   assign scan_start_pulse       = ctrl[C_SCANNER] & ctrl[C_EMIT] & ~fail[F_LASER] & ~div_reg[0];
   assign press_engaged_sensor   = pos_reg;
   assign press_retracted_sensor = ~pos_reg;
   assign belt_position_sensor   = belt_reg;
   assign cleaner_retract_sensor = clean_reg;
endmodule : emfm_partner

//--- tb/tb.sv
// self-checking bench of the engine motor fault monitor
`timescale 1ns/100ps

module tb;
   import emfm_pkg::*;
   localparam int TD = 2;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic              cover_open = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0;
   logic [CTRL_W-1:0] ctrl_v = '0;
   logic [7:0]        fail_v = 8'h00;
   logic [31:0]       prdata, q;
   logic              pready, pslverr, err, irq, fan_full, fan_half;
   logic              fl, tl, ul, sl, sp, pe, pr, bs, cs;
   int                fail_count = 0;
   int                comparisons = 0;
   int                lim;
   logic [7:0]        ra [8] = '{CTRL_OFS, STATUS_OFS, MASK_OFS, SOS_OFS, BELT_OFS, CLEAN_OFS,
                                 CMD_OFS, 8'h20};
   logic [31:0]       rv [8] = '{32'(CTRL_RST), 32'h0, 32'(MASK_RST), 32'(SOS_RST),
                                 32'(BELT_RST), 32'(CLEAN_RST), 32'h0, 32'h0};

   always #20 pclk = ~pclk;

   emfm_monitor #(.TICK_DIV(TD)) emfm_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cover_open(cover_open), .fan_lock(fl),
      .transport_lock(tl), .fuser_lock(ul), .scanner_lock(sl), .scan_start_pulse(sp),
      .press_engaged_sensor(pe), .press_retracted_sensor(pr), .belt_position_sensor(bs),
      .cleaner_retract_sensor(cs), .fan_full(fan_full), .fan_half(fan_half), .irq(irq));

   emfm_partner emfm_partner_i (.pclk(pclk), .presetn(presetn), .ctrl(ctrl_v), .fail(fail_v),
      .fan_lock(fl), .transport_lock(tl), .fuser_lock(ul), .scanner_lock(sl),
      .scan_start_pulse(sp), .press_engaged_sensor(pe), .press_retracted_sensor(pr),
      .belt_position_sensor(bs), .cleaner_retract_sensor(cs));

   task tally_and_finish;
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // one apb transfer, entered just after a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 16) begin
            fail_count++;
            tally_and_finish();
         end
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task wait_ms(input int n);
      repeat (n * TD) @(posedge pclk);
   endtask : wait_ms

   task setc(input logic [CTRL_W-1:0] c);
      ctrl_v <= c;
      apb(1'b1, CTRL_OFS, {20'h0, c});
   endtask : setc

   task stat(input int b, input logic e);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("status bit", {31'h0, e}, {31'h0, q[b]});
   endtask : stat

   task chkfan(input logic [1:0] e);
      repeat (4) @(posedge pclk);
      chk("fan drive", {30'h0, e}, {30'h0, fan_full, fan_half});
   endtask : chkfan

   // quiet until lo ms, flagged by hi ms, irq follows
   task fault(input int b, input int lo, input int hi);
      wait_ms(lo);
      stat(b, 1'b0);
      wait_ms(hi - lo);
      stat(b, 1'b1);
      chk("irq", 32'h1, {31'h0, irq});
   endtask : fault

   task clean;
      fail_v <= 8'h00;
      setc('0);
      apb(1'b1, STATUS_OFS, 32'h7f);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("status", 32'h0, q);
   endtask : clean

   // limit drawn at random, healthy run first, then the stall
   task sens(input int b, input logic [7:0] ofs, input logic [CTRL_W-1:0] c, input logic [7:0] f);
      lim = $urandom_range(60, 10);
      apb(1'b1, ofs, 32'(lim));
      setc(c);
      wait_ms(100);
      stat(b, 1'b0);
      fail_v <= f;
      fault(b, lim - 4, lim + 3);
      clean();
   endtask : sens

   initial begin
      void'($urandom(43857));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk("read", rv[i], q);
         chk("slverr", {31'h0, i == 7}, {31'h0, err});
      end
      // fan off, roller retracted, all windows closed
      apb(1'b0, STATE_OFS, 32'h0);
      chk("state", 32'h0000_0401, q);
      apb(1'b1, MASK_OFS, 32'h7f);
      setc(12'h001);
      apb(1'b1, CMD_OFS, 32'h1);
      chkfan(2'b10);
      wait_ms(1985);
      chkfan(2'b10);
      wait_ms(25);
      chkfan(2'b01);
      cover_open <= 1'b1;
      chkfan(2'b00);
      cover_open <= 1'b0;
      setc(12'h003);
      chkfan(2'b10);
      setc(12'h403);
      chkfan(2'b00);
      setc(12'h001);
      chkfan(2'b01);
      apb(1'b1, CMD_OFS, 32'h2);
      chkfan(2'b10);
      setc('0);
      chkfan(2'b00);
      fail_v <= 8'h01;
      wait_ms(450);
      fail_v <= 8'h00;
      wait_ms(1);
      fail_v <= 8'h01;
      fault(F_FAN, 450, 520);
      fail_v <= 8'h00;
      stat(F_FAN, 1'b1);
      apb(1'b1, MASK_OFS, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, MASK_OFS, 32'h7f);
      clean();
      for (int i = 1; i < 3; i++) begin
         setc(CTRL_W'(1 << i));
         fail_v <= 8'(1 << i);
         fault(i, 1400, 1520);
         clean();
      end
      setc(12'h018);
      wait_ms(4100);
      stat(F_PRESS, 1'b0);
      fail_v <= 8'h08;
      setc(12'h010);
      fault(F_PRESS, 3950, 4050);
      clean();
      // let the roller settle retracted, then jam it there and ask to engage
      wait_ms(40);
      fail_v <= 8'h08;
      setc(12'h018);
      fault(F_PRESS, 3950, 4050);
      clean();
      sens(F_LASER, SOS_OFS, 12'h060, 8'h10);
      setc(12'h020);
      fail_v <= 8'h80;
      fault(F_LASER, 8350, 8450);
      clean();
      sens(F_BELT, BELT_OFS, 12'h080, 8'h20);
      setc(12'h118);
      fail_v <= 8'h40;
      wait_ms(100);
      stat(F_CLEANER, 1'b0);
      clean();
      sens(F_CLEANER, CLEAN_OFS, 12'h318, 8'h40);
      tally_and_finish();
   end
endmodule : tb
